// [sio_irq_params.svh]
// register offsets, field positions, reset values and timing counts
// included by the design modules, not by the package
`ifndef SIO_IRQ_PARAMS_SVH
`define SIO_IRQ_PARAMS_SVH
`define ADR_RX_BUF 3'h0
`define ADR_INT_ENABLE 3'h1
`define ADR_FIFO_CTRL 3'h2
`define ADR_LINE_STAT 3'h5
`define ADR_MODEM_STAT 3'h6
`define ADR_SCRATCH 3'h7
`define IEN_RESET 4'h0
`define FCTL_TRIG_RESET 2'h0
`define FCTL_EN_RESET 1'h0
`define FCTL_TL_HI 7
`define FCTL_TL_LO 6
`define FCTL_TX_RST 2
`define FCTL_RX_RST 1
`define FCTL_FIFO_EN 0
`define HOLD_EMPTY_IDLE 1'h1
`define ID_NONE 4'h1
`define ID_RX_LINE 4'h6
`define ID_RX_AVAIL 4'h4
`define ID_CHAR_TMO 4'hC
`define ID_TX_EMPTY 4'h2
`define ID_MODEM 4'h0
`define TMO_CHAR_TIMES 4
`define TRIG_1 5'h01
`define TRIG_4 5'h04
`define TRIG_8 5'h08
`define TRIG_14 5'h0E
`endif

// [sio_irq_pkg.sv]
// types shared by the interrupt and fifo control logic
package sio_irq_pkg;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_RX_LINE = 3'b001,
    SRC_RX_AVAIL = 3'b010,
    SRC_CHAR_TMO = 3'b011,
    SRC_TX_EMPTY = 3'b100,
    SRC_MODEM = 3'b101
  } irq_src_t;
endpackage

// [char_timeout.sv]
// character timeout detector
// assumes char_tick pulses once per character time on REF_CLK
`timescale 1ns/1ps
`include "sio_irq_params.svh"
module char_timeout #(
  parameter int CHAR_TIMES = `TMO_CHAR_TIMES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic char_tick,
  input wire logic fifo_nonempty,
  input wire logic fifo_activity,
  input wire logic clear,
  output logic timeout
);
  logic [3:0] cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
    end else if (fifo_activity || !fifo_nonempty || clear) begin
      cnt_ff <= 4'h0;
    end else if (char_tick && cnt_ff < 4'(CHAR_TIMES)) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  assign timeout = fifo_nonempty && (cnt_ff >= 4'(CHAR_TIMES));
endmodule

// [sio_irq_ctrl.sv]
// interrupt identification, enable, scratch and fifo control registers
// assumes host strobes are synchronous to REF_CLK, one cycle each;
// status inputs come from receiver/transmitter logic on the same clock
`timescale 1ns/1ps
`include "sio_irq_params.svh"
module sio_irq_ctrl
  import sio_irq_pkg::*;
#(
  parameter int CHAR_TIMES = `TMO_CHAR_TIMES
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // host register port
  input wire logic [2:0] ADDR,
  input wire logic DIVISOR_LATCH_ACCESS,
  input wire logic RD,
  input wire logic WR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  // modem control interrupt-output bit
  input wire logic IRQ_OUT_EN,
  // event sources
  input wire logic LINE_ERR,
  input wire logic MODEM_DELTA,
  input wire logic TX_HOLD_EMPTY,
  input wire logic THR_WRITE,
  input wire logic [4:0] RX_FIFO_LEVEL,
  input wire logic RX_FIFO_ACTIVITY,
  input wire logic CHAR_TICK,
  // outputs
  output logic IRQ,
  output logic [1:0] RX_TRIGGER_LEVEL,
  output logic FIFO_ENABLE_BIT,
  output logic TX_FIFO_RESET,
  output logic RX_FIFO_RESET
);
  logic [3:0] ien_ff;
  logic [7:0] scratch_ff;
  logic [1:0] trig_sel_ff;
  logic fifo_en_ff;
  logic tx_rst_ff;
  logic rx_rst_ff;
  logic tx_empty_ff;
  logic thre_prev_ff;
  logic line_ff;
  logic modem_ff;
  irq_src_t frozen_ff;
  irq_src_t nxt_src;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic irq_ff;
  logic rd_ident;
  logic rd_rx;
  logic rd_lsr;
  logic rd_msr;
  logic wr_scratch;
  logic wr_fifo_ctrl;
  logic wr_ien;
  logic dl_reg;
  logic timeout;
  logic rx_nonempty;
  logic rx_avail;
  logic en_line_ctrl_irq;
  logic en_rx_line_irq;
  logic en_tx_empty_irq;
  logic en_rx_avail_irq;
  logic irq_pending_n;
  logic [3:0] irq_source_code;
  logic [7:0] irq_ident_reg;

  function automatic logic [4:0] trig_bytes(input logic [1:0] sel);
    case (sel)
      2'b00: trig_bytes = `TRIG_1;
      2'b01: trig_bytes = `TRIG_4;
      2'b10: trig_bytes = `TRIG_8;
      default: trig_bytes = `TRIG_14;
    endcase
  endfunction

  function automatic logic [3:0] src_code(input irq_src_t s);
    case (s)
      SRC_RX_LINE: src_code = `ID_RX_LINE;
      SRC_RX_AVAIL: src_code = `ID_RX_AVAIL;
      SRC_CHAR_TMO: src_code = `ID_CHAR_TMO;
      SRC_TX_EMPTY: src_code = `ID_TX_EMPTY;
      SRC_MODEM: src_code = `ID_MODEM;
      default: src_code = `ID_NONE;
    endcase
  endfunction

  // address 0 and 1 belong to the divisor latch when the access bit is set
  assign dl_reg = DIVISOR_LATCH_ACCESS;
  assign rd_ident = RD && ADDR == `ADR_FIFO_CTRL;
  assign rd_rx = RD && ADDR == `ADR_RX_BUF && !dl_reg;
  assign rd_lsr = RD && ADDR == `ADR_LINE_STAT;
  assign rd_msr = RD && ADDR == `ADR_MODEM_STAT;
  assign wr_fifo_ctrl = WR && ADDR == `ADR_FIFO_CTRL;
  assign wr_scratch = WR && ADDR == `ADR_SCRATCH;
  assign rx_nonempty = (RX_FIFO_LEVEL != 5'h00);
  assign wr_ien = WR && ADDR == `ADR_INT_ENABLE && !dl_reg;

  // enables only count while the interrupt-output bit is on
  assign en_rx_avail_irq = ien_ff[0] && IRQ_OUT_EN;
  assign en_tx_empty_irq = ien_ff[1] && IRQ_OUT_EN;
  assign en_rx_line_irq = ien_ff[2] && IRQ_OUT_EN;
  assign en_line_ctrl_irq = ien_ff[3] && IRQ_OUT_EN;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ien_ff <= `IEN_RESET;
    end else if (wr_ien) begin
      ien_ff <= WDATA[3:0];
    end
  end

  // no reset on purpose: contents are undefined after master reset
  always_ff @(posedge REF_CLK) begin
    if (wr_scratch) begin
      scratch_ff <= WDATA;
    end
  end

  // only the live fields are stored; reserved and unused bits are dropped
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      trig_sel_ff <= `FCTL_TRIG_RESET;
    end else if (wr_fifo_ctrl) begin
      trig_sel_ff <= WDATA[`FCTL_TL_HI:`FCTL_TL_LO];
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fifo_en_ff <= `FCTL_EN_RESET;
    end else if (wr_fifo_ctrl) begin
      fifo_en_ff <= WDATA[`FCTL_FIFO_EN];
    end
  end
  assign RX_TRIGGER_LEVEL = trig_sel_ff;
  assign FIFO_ENABLE_BIT = fifo_en_ff;

  // reset bits act only with fifo enable in the same write; one-cycle pulse
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_rst_ff <= 1'b0;
    end else begin
      tx_rst_ff <= wr_fifo_ctrl && WDATA[`FCTL_TX_RST]
        && WDATA[`FCTL_FIFO_EN];
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_rst_ff <= 1'b0;
    end else begin
      rx_rst_ff <= wr_fifo_ctrl && WDATA[`FCTL_RX_RST]
        && WDATA[`FCTL_FIFO_EN];
    end
  end
  assign TX_FIFO_RESET = tx_rst_ff;
  assign RX_FIFO_RESET = rx_rst_ff;

  char_timeout #(.CHAR_TIMES(CHAR_TIMES)) u_tmo (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .char_tick(CHAR_TICK),
    .fifo_nonempty(rx_nonempty),
    .fifo_activity(RX_FIFO_ACTIVITY),
    .clear(rd_rx),
    .timeout(timeout)
  );

  // data available is a level: falls with the fifo below trigger, or with fifos off when it empties
  always_comb begin
    if (fifo_en_ff) begin
      rx_avail = (RX_FIFO_LEVEL >= trig_bytes(trig_sel_ff));
    end else begin
      rx_avail = rx_nonempty;
    end
  end

  // sticky events; a new event in the clearing cycle wins
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      line_ff <= 1'b0;
    end else if (LINE_ERR) begin
      line_ff <= 1'b1;
    end else if (rd_lsr) begin
      line_ff <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      modem_ff <= 1'b0;
    end else if (MODEM_DELTA) begin
      modem_ff <= 1'b1;
    end else if (rd_msr) begin
      modem_ff <= 1'b0;
    end
  end

  // resets to the idle (empty) level so reset release is no false edge
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      thre_prev_ff <= `HOLD_EMPTY_IDLE;
    end else begin
      thre_prev_ff <= TX_HOLD_EMPTY;
    end
  end

  // tx empty flag sets on the rising edge of holding-empty
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_empty_ff <= 1'b0;
    end else if (TX_HOLD_EMPTY && !thre_prev_ff) begin
      tx_empty_ff <= 1'b1;
    end else if (THR_WRITE) begin
      tx_empty_ff <= 1'b0;
    end else if (rd_ident && frozen_ff == SRC_TX_EMPTY) begin
      tx_empty_ff <= 1'b0;
    end
  end

  always_comb begin
    if (line_ff && en_rx_line_irq) begin
      nxt_src = SRC_RX_LINE;
    end else if (timeout && en_rx_avail_irq) begin
      nxt_src = SRC_CHAR_TMO;
    end else if (rx_avail && en_rx_avail_irq) begin
      nxt_src = SRC_RX_AVAIL;
    end else if (tx_empty_ff && en_tx_empty_irq) begin
      nxt_src = SRC_TX_EMPTY;
    end else if (modem_ff && en_line_ctrl_irq) begin
      nxt_src = SRC_MODEM;
    end else begin
      nxt_src = SRC_NONE;
    end
  end

  // held while the ident register is addressed for reading
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      frozen_ff <= SRC_NONE;
    end else if (!rd_ident) begin
      frozen_ff <= nxt_src;
    end
  end

  assign irq_source_code = src_code(frozen_ff);
  assign irq_pending_n = (frozen_ff == SRC_NONE);
  assign irq_ident_reg = {{2{fifo_en_ff}}, 2'b00,
    irq_source_code[3:1], irq_pending_n};

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (nxt_src != SRC_NONE);
    end
  end
  assign IRQ = irq_ff;

  // read data holds until the next read strobe
  always_comb begin
    nxt_rdata = rdata_ff;
    if (RD) begin
      case (ADDR)
        `ADR_INT_ENABLE: begin
          nxt_rdata = dl_reg ? 8'h00 : {4'h0, ien_ff};
        end
        `ADR_FIFO_CTRL: begin
          nxt_rdata = irq_ident_reg;
        end
        `ADR_SCRATCH: begin
          nxt_rdata = scratch_ff;
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign RDATA = rdata_ff;
endmodule

// [sio_irq_chk_props.sv]
// checker for the host port and fifo control outputs
// assumes it is bound to every sio_irq_ctrl instance
`timescale 1ns/1ps
module sio_irq_chk #(
  parameter int CHAR_TIMES = 4
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // host port
  input wire logic [2:0] ADDR,
  input wire logic DIVISOR_LATCH_ACCESS,
  input wire logic RD,
  input wire logic WR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  // interrupt-output bit and outputs
  input wire logic IRQ_OUT_EN,
  input wire logic IRQ,
  input wire logic [1:0] RX_TRIGGER_LEVEL,
  input wire logic FIFO_ENABLE_BIT,
  input wire logic TX_FIFO_RESET,
  input wire logic RX_FIFO_RESET
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  logic fw;
  assign fw = WR && ADDR == 3'h2;
  property p_tx;
    fw && WDATA[2] && WDATA[0] |=> TX_FIFO_RESET ##1
      (!TX_FIFO_RESET || $past(fw && WDATA[2] && WDATA[0]));
  endproperty
  property p_rx;
    fw && WDATA[1] && WDATA[0] |=> RX_FIFO_RESET ##1
      (!RX_FIFO_RESET || $past(fw && WDATA[1] && WDATA[0]));
  endproperty
  property p_ref;
    fw && !WDATA[0] |=> !TX_FIFO_RESET && !RX_FIFO_RESET;
  endproperty
  property p_trig;
    fw |=> RX_TRIGGER_LEVEL == $past(WDATA[7:6]) &&
      FIFO_ENABLE_BIT == $past(WDATA[0]);
  endproperty
  property p_mask;
    !IRQ_OUT_EN [*3] |-> !IRQ;
  endproperty
  property p_ien;
    RD && ADDR == 3'h1 && DIVISOR_LATCH_ACCESS |=> RDATA == 8'h00;
  endproperty
  property p_id;
    RD && ADDR == 3'h2 |=> RDATA[5:4] == 2'b00 && RDATA[7] == RDATA[6];
  endproperty
  property p_unmap;
    RD && ADDR == 3'h3 |=> RDATA == 8'h00;
  endproperty
  a_tx: assert property (p_tx) else $error("tx reset pulse");
  a_rx: assert property (p_rx) else $error("rx reset pulse");
  a_ref: assert property (p_ref) else $error("reset w/o enable");
  a_trig: assert property (p_trig) else $error("trigger level");
  a_mask: assert property (p_mask) else $error("irq not masked");
  a_ien: assert property (p_ien) else $error("enable under dla");
  a_id: assert property (p_id) else $error("ident fixed bits");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind sio_irq_ctrl sio_irq_chk #(.CHAR_TIMES(CHAR_TIMES)) u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .RD(RD), .WR(WR),
  .DIVISOR_LATCH_ACCESS(DIVISOR_LATCH_ACCESS), .WDATA(WDATA),
  .RDATA(RDATA), .IRQ_OUT_EN(IRQ_OUT_EN), .IRQ(IRQ),
  .RX_TRIGGER_LEVEL(RX_TRIGGER_LEVEL), .FIFO_ENABLE_BIT(FIFO_ENABLE_BIT),
  .TX_FIFO_RESET(TX_FIFO_RESET), .RX_FIFO_RESET(RX_FIFO_RESET));

// [host_model.sv]
// host processor model: one-cycle read and write strobes
// assumes read data is registered, valid the cycle after the strobe
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [2:0] addr,
  output logic rd,
  output logic wr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 3'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 8'h00;
  end
  // waits an edge first, so back-to-back calls never retoggle a strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = (a == 3'h2) ? (d & 8'hCF) : d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdata;
  endtask
endmodule

// [testbench.sv]
// self-checking bench for interrupt ident, enable and fifo control
// assumes host_model and the bound checker are compiled first
`timescale 1ns/1ps
module testbench;
  localparam int CT = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dla = 1'b0, ien = 1'b0, le = 1'b0, md = 1'b0, te = 1'b0;
  logic tw = 1'b0, act = 1'b0, tk = 1'b0;
  logic [4:0] lvl = 5'h00;
  logic [4:0] tl [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  logic [2:0] addr;
  logic rd, wr, irq, fen, txr, rxr;
  logic [7:0] wdata, rdata, v;
  logic [1:0] trig;
  int n_mismatch = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  host_model h (.clk(clk), .addr(addr), .rd(rd), .wr(wr),
    .wdata(wdata), .rdata(rdata));
  sio_irq_ctrl #(.CHAR_TIMES(CT)) dut (.REF_CLK(clk), .RSTN(rst_n),
    .ADDR(addr), .DIVISOR_LATCH_ACCESS(dla), .RD(rd), .WR(wr),
    .WDATA(wdata), .RDATA(rdata), .IRQ_OUT_EN(ien), .LINE_ERR(le),
    .MODEM_DELTA(md), .TX_HOLD_EMPTY(te), .THR_WRITE(tw),
    .RX_FIFO_LEVEL(lvl), .RX_FIFO_ACTIVITY(act), .CHAR_TICK(tk),
    .IRQ(irq), .RX_TRIGGER_LEVEL(trig), .FIFO_ENABLE_BIT(fen),
    .TX_FIFO_RESET(txr), .RX_FIFO_RESET(rxr));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic id(input logic [7:0] e);
    h.rd_reg(3'h2, v);
    chk(v, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    cyc(2);
    rst_n = 1'b1;
    h.rd_reg(3'h1, v);
    chk(v, 8'h00);
    id(8'h01);
    h.wr_reg(3'h1, 8'hFF);
    dla = 1'b1;
    h.wr_reg(3'h1, 8'h00);
    h.rd_reg(3'h1, v);
    chk(v, 8'h00);
    dla = 1'b0;
    h.rd_reg(3'h1, v);
    chk(v, 8'h0F);
    h.wr_reg(3'h7, 8'hA5);
    h.rd_reg(3'h7, v);
    chk(v, 8'hA5);
    h.rd_reg(3'h3, v);
    chk(v, 8'h00);
    $display("test registers done");
    le = 1'b1;
    cyc(1);
    le = 1'b0;
    cyc(3);
    id(8'h01);
    ien = 1'b1;
    cyc(3);
    id(8'h06);
    md = 1'b1;
    cyc(1);
    md = 1'b0;
    te = 1'b1;
    lvl = 5'h01;
    cyc(3);
    id(8'h06);
    chk({7'h00, irq}, 8'h01);
    h.rd_reg(3'h5, v);
    cyc(3);
    id(8'h04);
    lvl = 5'h00;
    cyc(3);
    id(8'h02);
    cyc(3);
    id(8'h00);
    te = 1'b0;
    cyc(1);
    te = 1'b1;
    cyc(1);
    tw = 1'b1;
    cyc(1);
    tw = 1'b0;
    cyc(3);
    id(8'h00);
    te = 1'b0;
    cyc(1);
    te = 1'b1;
    cyc(3);
    le = 1'b1;
    fork
      h.rd_reg(3'h2, v);
      begin
        cyc(1);
        le = 1'b0;
      end
    join
    chk(v, 8'h02);
    h.rd_reg(3'h5, v);
    cyc(3);
    id(8'h00);
    h.rd_reg(3'h6, v);
    cyc(3);
    id(8'h01);
    chk({7'h00, irq}, 8'h00);
    $display("test interrupts done");
    h.wr_reg(3'h2, 8'hC1);
    chk({7'h00, fen}, 8'h01);
    lvl = 5'h01;
    for (int i = 0; i < CT; i++) begin
      cyc(3);
      id(8'hC1);
      tk = 1'b1;
      cyc(1);
      tk = 1'b0;
    end
    cyc(3);
    id(8'hCC);
    h.rd_reg(3'h0, v);
    cyc(3);
    id(8'hC1);
    for (int i = 0; i < 4; i++) begin
      h.wr_reg(3'h2, {i[1:0], 6'h01});
      chk({6'h00, trig}, {6'h00, i[1:0]});
      lvl = tl[i] - 5'h01;
      cyc(3);
      id(8'hC1);
      lvl = tl[i];
      cyc(3);
      id(8'hC4);
    end
    lvl = 5'h00;
    h.wr_reg(3'h2, 8'h07);
    chk({6'h00, txr, rxr}, 8'h03);
    cyc(1);
    chk({6'h00, txr, rxr}, 8'h00);
    h.wr_reg(3'h2, 8'h06);
    chk({6'h00, txr, rxr}, 8'h00);
    id(8'h01);
    $display("test fifo done");
    h.wr_reg(3'h2, 8'hC1);
    rst_n = 1'b0;
    cyc(2);
    chk({5'h00, trig, fen}, 8'h00);
    rst_n = 1'b1;
    h.rd_reg(3'h1, v);
    chk(v, 8'h00);
    $display("test reset done");
    report_and_stop();
  end
endmodule
